/* logic/port_irq_defs.svh */
`ifndef PORT_IRQ_DEFS_SVH
`define PORT_IRQ_DEFS_SVH

// register indexes; byte address is four times the index
`define IDX_P0_FLAGS 8'h89
`define IDX_P1_FLAGS 8'h8a
`define IDX_P2_FLAGS 8'h8b
`define IDX_EDGE_CTRL 8'h8c
`define IDX_P1_IRQ_EN 8'h8d
`define IDX_P2_INMODE 8'hf7
`define IDX_IRQ_STATUS 8'he0
`define IDX_IRQ_MASK 8'he1

// input mode control fields
`define INMODE_P2_DIR_BIT 7
`define INMODE_P1_DIR_BIT 6
`define INMODE_P0_DIR_BIT 5
`define INMODE_P2_MODE_MSB 4
`define INMODE_RESET 8'h00

// edge control fields
`define EDGE_P0_POL_BIT 0
`define EDGE_P1_POL_BIT 1
`define EDGE_P2_POL_BIT 2
`define EDGE_P0_LO_EN_BIT 3
`define EDGE_P0_HI_EN_BIT 4
`define EDGE_P2_EN_BIT 5
`define EDGE_CTRL_MSB 5
`define EDGE_RESET 8'h00

// interrupt status / mask fields
`define IRQ_P0_BIT 0
`define IRQ_P1_BIT 1
`define IRQ_P2_BIT 2
`define IRQ_USB_BIT 3
`define IRQ_MSB 3

// port 0 flag layout, and the port 1 pins without pull
`define P0_USB_RESUME_BIT 7
`define P0_UNUSED_BIT 6
`define P0_USB_PIN_MSB 5
`define P0_LOWER_MSB 3
`define P0_UPPER_LSB 4
`define P1_NO_PULL_MSB 1

`define FLAGS_RESET 8'h00

`endif

/* logic/port_irq_pkg.sv */
package port_irq_pkg;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } av_req_t;

  typedef struct packed {
    logic [7:0] port0;
    logic [7:0] port1;
    logic [4:0] port2;
  } pin_set_t;

  typedef enum logic {
    EDGE_RISING,
    EDGE_FALLING
  } edge_pol_t;

endpackage : port_irq_pkg

/* logic/port_input_mode_irq.sv */
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
`include "port_irq_defs.svh"

// What this block does
// RULE1: one port-2 pull selector, 0 pull-up 1 pull-down, reset 0, serves port-2 pins in pull mode.
// RULE2: one port-1 pull selector serves port-1 pins in pull mode, pins 0 and 1 have no pull.
// RULE3: one port-0 pull selector, 0 pull-up 1 pull-down, reset 0, serves port-0 pins in pull mode.
// RULE4: five per-pin port-2 input mode bits, 0 pull and 1 tristate, reset all zero.
// RULE5: without usb, eight port-0 pending flags for pins 7 to 0, 1 pending, reset zero.
// RULE6: with usb, port-0 flag bit 7 shows usb resume during suspend and bit 6 is unused and 0.
// RULE7: with usb, port-0 pending flags exist for pins 5 to 0 only, reset zero.
// RULE8: eight port-1 pending flags for pins 7 to 0, 1 pending, reset zero.
// RULE9: five port-2 pending flags in bits 4 to 0, bits 7 to 5 read zero.
// RULE10: per port one edge polarity bit, 0 rising and 1 falling edge sets the flag.
// RULE11: port-1 pins enabled singly, port 0 in groups 7-4 and 3-0, port 2 as one group.
// RULE12: hardware sets a flag on the chosen edge, writing 0 clears it, writing 1 keeps it.
// RULE13: a set and a clear of one flag in the same cycle leave the flag set.
module port_input_mode_irq
  import port_irq_pkg::*;
#(
  parameter int USB_VARIANT = 0
)
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [7:0] port0_pins_in,
  input wire logic [7:0] port1_pins_in,
  input wire logic [4:0] port2_pins_in,
  input wire logic usb_resume_in,
  output logic port0_pull_dir_out,
  output logic [7:0] port1_pull_dir_out,
  output logic port2_pull_dir_out,
  output logic [4:0] port2_pin_input_mode_out,
  output logic irq_out
);

  initial
  begin
    if (USB_VARIANT != 0 && USB_VARIANT != 1)
      $error("USB_VARIANT must be 0 or 1");
  end

  av_req_t req;
  pin_set_t pins_in;
  pin_set_t sync1_reg, sync2_reg, prev_reg;
  pin_set_t rise, fall;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] inmode_reg, inmode_next;
  logic [7:0] edge_reg, edge_next;
  logic [7:0] p1_en_reg, p1_en_next;
  logic [7:0] p0_flags_reg, p0_flags_next;
  logic [7:0] p1_flags_reg, p1_flags_next;
  logic [7:0] p2_flags_reg, p2_flags_next;
  logic [7:0] irq_stat_reg, irq_stat_next;
  logic [7:0] irq_mask_reg, irq_mask_next;
  logic commit;
  logic [7:0] p0_set, p1_set, p2_set;
  logic [7:0] p0_en;
  logic [7:0] irq_ev;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a == idx);
  endfunction : hit

  // hw set beats sw write-0 clear in the same cycle
  function automatic logic [7:0] w0c(input logic [7:0] cur,
    input logic [7:0] set, input logic wr, input logic [7:0] wd);
    logic [7:0] clr;
    clr = wr ? ~wd : 8'h00; // RULE12
    w0c = (cur & ~clr) | set; // RULE13
  endfunction : w0c

  assign req = '{address: avs_address_in, read: avs_read_in,
                 write: avs_write_in, writedata: avs_writedata_in};
  assign pins_in = '{port0: port0_pins_in, port1: port1_pins_in,
                     port2: port2_pins_in};

  // one wait cycle per access; read data registered at the ack edge
  assign avs_waitrequest_out = (req.read | req.write) & ~ack_reg;
  assign commit = req.write & ack_reg;
  assign avs_readdata_out = rdata_reg;

  // pins are asynchronous: two flops before edge logic
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  always_comb
  begin
    // edge choice per port
    p0_set = edge_reg[`EDGE_P0_POL_BIT] ? fall.port0 : rise.port0; // RULE10
    p1_set = edge_reg[`EDGE_P1_POL_BIT] ? fall.port1 : rise.port1; // RULE10
    p2_set = {3'h0, edge_reg[`EDGE_P2_POL_BIT] ? fall.port2
                                                : rise.port2}; // RULE10 RULE9
    if (USB_VARIANT != 0)
    begin
      p0_set[`P0_UNUSED_BIT] = 1'b0; // RULE6 RULE7
      p0_set[`P0_USB_RESUME_BIT] = usb_resume_in; // RULE6
    end
    // enables gate only the interrupt, flags record every edge of the chosen polarity except on port-0 pins 7 and 6 in the usb variant
    p0_en = {{4{edge_reg[`EDGE_P0_HI_EN_BIT]}},
             {4{edge_reg[`EDGE_P0_LO_EN_BIT]}}}; // RULE11
    if (USB_VARIANT != 0)
      p0_en[`P0_USB_RESUME_BIT] = 1'b0;
    irq_ev = 8'h00;
    irq_ev[`IRQ_P0_BIT] = |(p0_set & p0_en); // RULE11
    irq_ev[`IRQ_P1_BIT] = |(p1_set & p1_en_reg); // RULE11
    irq_ev[`IRQ_P2_BIT] = (|p2_set) & edge_reg[`EDGE_P2_EN_BIT]; // RULE11
    irq_ev[`IRQ_USB_BIT] = (USB_VARIANT != 0) & usb_resume_in;
  end

  always_comb
  begin
    ack_next = (req.read | req.write) & ~ack_reg;
    rdata_next = rdata_reg;
    inmode_next = inmode_reg;
    edge_next = edge_reg;
    p1_en_next = p1_en_reg;
    irq_mask_next = irq_mask_reg;
    if (req.read & ~ack_reg)
    begin
      rdata_next = 32'h0000_0000;
      if (hit(req.address, `IDX_P0_FLAGS))
        rdata_next[7:0] = p0_flags_reg;
      if (hit(req.address, `IDX_P1_FLAGS))
        rdata_next[7:0] = p1_flags_reg;
      if (hit(req.address, `IDX_P2_FLAGS))
        rdata_next[7:0] = p2_flags_reg;
      if (hit(req.address, `IDX_EDGE_CTRL))
        rdata_next[7:0] = edge_reg;
      if (hit(req.address, `IDX_P1_IRQ_EN))
        rdata_next[7:0] = p1_en_reg;
      if (hit(req.address, `IDX_P2_INMODE))
        rdata_next[7:0] = inmode_reg;
      if (hit(req.address, `IDX_IRQ_STATUS))
        rdata_next[7:0] = irq_stat_reg;
      if (hit(req.address, `IDX_IRQ_MASK))
        rdata_next[7:0] = irq_mask_reg;
    end
    if (commit & hit(req.address, `IDX_P2_INMODE))
      inmode_next = req.writedata[7:0]; // RULE1 RULE2 RULE3 RULE4
    if (commit & hit(req.address, `IDX_EDGE_CTRL))
    begin
      edge_next = 8'h00;
      edge_next[`EDGE_CTRL_MSB:0] = req.writedata[`EDGE_CTRL_MSB:0];
    end
    if (commit & hit(req.address, `IDX_P1_IRQ_EN))
      p1_en_next = req.writedata[7:0];
    if (commit & hit(req.address, `IDX_IRQ_MASK))
    begin
      irq_mask_next = 8'h00;
      irq_mask_next[`IRQ_MSB:0] = req.writedata[`IRQ_MSB:0];
    end
  end

  always_comb
  begin
    p0_flags_next = w0c(p0_flags_reg, p0_set,
      commit & hit(req.address, `IDX_P0_FLAGS),
      req.writedata[7:0]); // RULE5 RULE7
    p1_flags_next = w0c(p1_flags_reg, p1_set,
      commit & hit(req.address, `IDX_P1_FLAGS),
      req.writedata[7:0]); // RULE8
    p2_flags_next = w0c(p2_flags_reg, p2_set,
      commit & hit(req.address, `IDX_P2_FLAGS),
      req.writedata[7:0]) & 8'h1f; // RULE9
    if (USB_VARIANT != 0)
      p0_flags_next[`P0_UNUSED_BIT] = 1'b0; // RULE6
    // status is write-one-to-clear, set wins here as well
    irq_stat_next = irq_stat_reg;
    if (commit & hit(req.address, `IDX_IRQ_STATUS))
      irq_stat_next = irq_stat_reg & ~req.writedata[7:0];
    irq_stat_next = irq_stat_next | irq_ev;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      inmode_reg <= `INMODE_RESET; // RULE1 RULE3 RULE4
      edge_reg <= `EDGE_RESET;
      p1_en_reg <= `FLAGS_RESET;
      p0_flags_reg <= `FLAGS_RESET; // RULE5 RULE7
      p1_flags_reg <= `FLAGS_RESET; // RULE8
      p2_flags_reg <= `FLAGS_RESET;
      irq_stat_reg <= `FLAGS_RESET;
      irq_mask_reg <= `FLAGS_RESET;
    end
    else
    begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      inmode_reg <= inmode_next;
      edge_reg <= edge_next;
      p1_en_reg <= p1_en_next;
      p0_flags_reg <= p0_flags_next;
      p1_flags_reg <= p1_flags_next;
      p2_flags_reg <= p2_flags_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  assign port2_pull_dir_out = inmode_reg[`INMODE_P2_DIR_BIT]; // RULE1
  assign port0_pull_dir_out = inmode_reg[`INMODE_P0_DIR_BIT]; // RULE3
  // pins 1:0 of port 1 cannot pull, so they never see the selector
  assign port1_pull_dir_out = {{6{inmode_reg[`INMODE_P1_DIR_BIT]}},
                               2'h0}; // RULE2
  assign port2_pin_input_mode_out =
    inmode_reg[`INMODE_P2_MODE_MSB:0]; // RULE4
  assign irq_out = |(irq_stat_reg & irq_mask_reg);

endmodule : port_input_mode_irq

/* bench/pin_stub.sv */
`timescale 1ns/10ps
module pin_stub
  import port_irq_pkg::*;
(
  input wire logic clk_sys_in,
  input wire pin_set_t level_in,
  output pin_set_t pins_out
);
  // pins move just after an edge, never on it
  always_ff @(posedge clk_sys_in)
  begin
    pins_out <= level_in;
  end
endmodule : pin_stub

/* bench/port_input_mode_irq_sva.sv */
`timescale 1ns/10ps
module port_input_mode_irq_sva
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic port0_pull_dir_out,
  input wire logic [7:0] port1_pull_dir_out,
  input wire logic port2_pull_dir_out,
  input wire logic [4:0] port2_pin_input_mode_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  logic wm;
  logic rm;
  assign wm = avs_write_in && !avs_waitrequest_out
    && avs_address_in == 8'hf7;
  assign rm = avs_read_in && !avs_waitrequest_out;
  property p_r1;
    wm |=> port2_pull_dir_out == $past(avs_writedata_in[7]);
  endproperty
  a_r1: assert property (p_r1) else $error("p2 pull");
  property p_r2;
    wm |=> port1_pull_dir_out[7:2] == {6{$past(avs_writedata_in[6])}};
  endproperty
  a_r2: assert property (p_r2) else $error("p1 pull");
  property p_r2lo;
    port1_pull_dir_out[1:0] == 2'h0;
  endproperty
  a_r2lo: assert property (p_r2lo) else $error("p1 low");
  property p_r3;
    wm |=> port0_pull_dir_out == $past(avs_writedata_in[5]);
  endproperty
  a_r3: assert property (p_r3) else $error("p0 pull");
  property p_r4;
    wm |=> port2_pin_input_mode_out == $past(avs_writedata_in[4:0]);
  endproperty
  a_r4: assert property (p_r4) else $error("mode");
  property p_r4s;
    !wm |=> $stable(port2_pin_input_mode_out);
  endproperty
  a_r4s: assert property (p_r4s) else $error("mode moved");
  property p_rst;
    $fell(srst_in) |-> !port0_pull_dir_out && !port2_pull_dir_out
      && port2_pin_input_mode_out == 5'h00 && !irq_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_r9;
    rm && avs_address_in == 8'h8b |-> avs_readdata_out[7:5] == 3'h0;
  endproperty
  a_r9: assert property (p_r9) else $error("p2 flags");
  c_w: cover property (wm);
  c_irq: cover property ($rose(irq_out));
  c_r9: cover property (rm && avs_address_in == 8'h8b);
endmodule : port_input_mode_irq_sva
bind port_input_mode_irq port_input_mode_irq_sva u_sva (.*);

/* bench/test_port_input_mode_irq.sv */
`timescale 1ns/10ps
module test_port_input_mode_irq
  import port_irq_pkg::*;
;
  logic clk_sys_in = 0, srst_in = 1, rd = 0, wr = 0, wq, p0d, p2d, irq;
  logic [7:0] addr = 8'h00, p1d, r;
  logic [31:0] wd = 32'h0, rdata;
  logic [4:0] mode;
  pin_set_t lvl = '0, pins;
  logic [31:0] exp_q[$];
  logic usb = 0, usb_exp = 0;
  logic [31:0] rdata_u;
  logic [31:0] exp_u[$];
  int err_count = 0, checks_done = 0, cyc = 0;
  initial
  begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  pin_stub u_pin_stub (.clk_sys_in(clk_sys_in), .level_in(lvl),
    .pins_out(pins));
  port_input_mode_irq u_port_input_mode_irq (.clk_sys_in(clk_sys_in),
    .srst_in(srst_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wq), .port0_pins_in(pins.port0),
    .port1_pins_in(pins.port1), .port2_pins_in(pins.port2),
    .usb_resume_in(1'b0), .port0_pull_dir_out(p0d),
    .port1_pull_dir_out(p1d), .port2_pull_dir_out(p2d),
    .port2_pin_input_mode_out(mode), .irq_out(irq));
  // usb variant shares bus and pins, only its read data is compared
  port_input_mode_irq #(.USB_VARIANT(1)) u_port_input_mode_irq_usb (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_readdata_out(rdata_u), .avs_waitrequest_out(),
    .port0_pins_in(pins.port0), .port1_pins_in(pins.port1),
    .port2_pins_in(pins.port2), .usb_resume_in(usb),
    .port0_pull_dir_out(), .port1_pull_dir_out(),
    .port2_pull_dir_out(), .port2_pin_input_mode_out(), .irq_out());
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH %0t %h %h", $time, s, e);
    end
  endtask : chk
  task end_sim;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  task wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wd <= {24'h0, d};
    wr <= 1'b1;
    @(posedge clk_sys_in iff !wq);
    wr <= 1'b0;
  endtask : wrr
  task rdd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back({24'h0, e});
    exp_u.push_back({24'h0, (a == 8'h89) ? {usb_exp, 1'b0, e[5:0]} : e});
    @(posedge clk_sys_in iff !wq);
    rd <= 1'b0;
  endtask : rdd
  // one read noted per completed transfer, oldest first
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (rd && !wq)
    begin
      chk(rdata, exp_q.pop_front());
      chk(rdata_u, exp_u.pop_front());
    end
    if (cyc == 3000)
    begin
      err_count++;
      end_sim();
    end
  end
  initial
  begin
    void'($urandom(15));
    repeat (6) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    rdd(8'h89, 8'h00);
    rdd(8'h8a, 8'h00);
    rdd(8'h8b, 8'h00);
    rdd(8'hf7, 8'h00);
    wrr(8'h10, 8'hff);
    rdd(8'h10, 8'h00);
    repeat (3)
    begin
      r = 8'($urandom);
      wrr(8'hf7, r);
      rdd(8'hf7, r);
      chk(32'(p2d), 32'(r[7]));
      chk(32'(p1d), 32'({{6{r[6]}}, 2'h0}));
      chk(32'(p0d), 32'(r[5]));
      chk(32'(mode), 32'(r[4:0]));
    end
    wrr(8'h8c, 8'h38);
    wrr(8'h8d, 8'hff);
    lvl <= '{port0: 8'hff, port1: r, port2: 5'h1f};
    repeat (6) @(posedge clk_sys_in);
    chk(32'(irq), 32'h0);
    rdd(8'h89, 8'hff);
    rdd(8'h8a, r);
    rdd(8'h8b, 8'h1f);
    rdd(8'he0, {5'h0, 1'b1, |r, 1'b1});
    wrr(8'he1, 8'h07);
    @(posedge clk_sys_in);
    chk(32'(irq), 32'h1);
    wrr(8'h89, 8'h0f);
    rdd(8'h89, 8'h0f);
    wrr(8'he0, 8'h07);
    wrr(8'h89, 8'h00);
    wrr(8'h8b, 8'h00);
    rdd(8'he0, 8'h00);
    chk(32'(irq), 32'h0);
    wrr(8'h8c, 8'h3f);
    lvl <= '0;
    repeat (6) @(posedge clk_sys_in);
    rdd(8'h89, 8'hff);
    rdd(8'h8b, 8'h1f);
    wrr(8'h8a, 8'h00);
    lvl <= '1;
    repeat (6) @(posedge clk_sys_in);
    rdd(8'h8a, 8'h00);
    usb <= 1'b1;
    @(posedge clk_sys_in);
    usb <= 1'b0;
    usb_exp = 1'b1;
    rdd(8'h89, 8'hff);
    end_sim();
  end
endmodule : test_port_input_mode_irq
